// ==== design/nand_host_consts.vh ====
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH
// Behaviour
// RULE_01: Command byte latched on write strobe rise with command latch high.
// RULE_02: Device latches address with address latch high, data with it low.
// RULE_03: Device holds ready/busy low during program, erase or page fetch.
// RULE_04: Write guard low blocks program and erase inside the device.
// RULE_05: Latch levels pick command, three address clocks, data or standby.
// RULE_06: Spare select high keeps the 16 spare bytes out of reads, programs.
// RULE_07: A page fetch into the page register takes at most 7 us.
// RULE_08: Sequential read goes busy within 100 ns of the last read strobe.
// RULE_09: Deselect within 30 ns of the last read strobe suppresses that busy.
// RULE_10: Host ends a sequential read holding select high over 100 ns.
// RULE_11: Host does at most 10 partial programs per page between erases; the code counts per target block and also clears on a REG_BLOCK write.
// RULE_12: Host never programs or erases a block known to be invalid.
// RULE_13: Device keeps at least 1014 of 1024 blocks valid over its life.
// RULE_14: Block zero is always valid and needs no check.
// RULE_15: Shipped invalid blocks carry a 00h marker in page one or two.
// RULE_16: Shipped, every other location reads erased as FFh.
// RULE_17: Host builds the invalid-block table from markers before any erase.
// RULE_18: Host never deliberately erases the factory markers.
// RULE_19: Host maps addresses so invalid blocks never hold data.
// RULE_20: Failed program or erase status makes the host retire the block; the code never retires block zero.
// RULE_21: Single-bit read errors are corrected by code, block kept.
// RULE_22: Host code corrects one-bit and detects two-bit errors per unit.
`define CLK_PERIOD_NS 13'h0008
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 13'h0001) / `CLK_PERIOD_NS)
`define WE_LOW_NS 13'h0019
`define WRITE_CYCLE_NS 13'h0032
`define READ_ACCESS_NS 13'h0023
`define WB_NS 13'h0064
`define SELECT_HIGH_HOLD_NS 13'h0064
`define PAGE_FETCH_TIME_US 13'h0007
`define SYNC_DEPTH 13'h0003
`define WE_LOW_CYC `CEIL_CYC(`WE_LOW_NS)
`define WE_HIGH_CYC `CEIL_CYC(`WRITE_CYCLE_NS - `WE_LOW_NS)
`define RD_LOW_CYC (`CEIL_CYC(`READ_ACCESS_NS) + `SYNC_DEPTH)
`define WB_CYC `CEIL_CYC(`WB_NS)
`define SELECT_HIGH_HOLD_CYC (`CEIL_CYC(`SELECT_HIGH_HOLD_NS) + 13'h0001)
`define PAGE_FETCH_CYC ((`PAGE_FETCH_TIME_US * 13'h03E8) / `CLK_PERIOD_NS)
`define REG_CMD 8'h00
`define REG_CFG 8'h04
`define REG_STATUS 8'h08
`define REG_BLOCK 8'h0C
`define REG_ECC 8'h10
`define OP_CMD 3'h1
`define OP_ADDR 3'h2
`define OP_WDATA 3'h3
`define OP_RDATA 3'h4
`define OP_WAIT 3'h5
`define OP_END 3'h6
`define CMD_PROG_CONFIRM 8'h10
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_STATUS 8'h70
`define MARK_BAD 8'h00
`define ERASED 8'hFF
`define PARTIAL_MAX 4'hA
`define ADDR_CLOCKS 2'h3
`define BLOCKS 11'h400
`define VALID_BLOCK_MIN 11'h3F6
`endif

// ==== design/pin_sync.v ====
`timescale 1ns/1ns
module pin_sync #(
	parameter W = 9
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] pin,
	output wire [W-1:0] stable
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1;
			reg s2;
			reg s3;
			reg held;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					held <= 1'b0;
				end else begin
					s1 <= pin[i];
					s2 <= s1;
					s3 <= s2;
					// A change counts only once two stages agree
					if (s2 == s3)
						held <= s3;
				end
			end
			assign stable[i] = held;
		end
	endgenerate
endmodule // pin_sync

// ==== design/ecc_secded.v ====
`timescale 1ns/1ns
module ecc_secded (
	input wire [7:0] data,
	input wire [4:0] check,
	output wire [4:0] gen,
	output wire [7:0] fixed,
	output wire single_err,
	output wire double_err
);
	// Hamming positions of the data bits, highest bit first
	localparam [31:0] POS = {4'hC, 4'hB, 4'hA, 4'h9,
		4'h7, 4'h6, 4'h5, 4'h3};
	wire [3:0] p;
	wire [3:0] syn;
	wire odd;
	assign p[0] = data[0] ^ data[1] ^ data[3] ^ data[4] ^ data[6];
	assign p[1] = data[0] ^ data[2] ^ data[3] ^ data[5] ^ data[6];
	assign p[2] = data[1] ^ data[2] ^ data[3] ^ data[7];
	assign p[3] = data[4] ^ data[5] ^ data[6] ^ data[7];
	assign gen = {^{data, p}, p};
	assign syn = p ^ check[3:0];
	assign odd = ^{data, check};
	assign single_err = odd; // RULE_22
	assign double_err = !odd && (syn != 4'h0); // RULE_22
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_fix
			// Odd parity plus a matching syndrome flips one bit
			assign fixed[i] = data[i] ^ (odd && (syn == POS[4*i +: 4])); // RULE_21
		end
	endgenerate
endmodule // ecc_secded

// ==== design/nand_host.v ====
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "nand_host_consts.vh"
module nand_host (
	input wire clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	output reg chip_select_n,
	output reg cmd_latch,
	output reg addr_latch,
	output reg write_strobe_n,
	output reg read_strobe_low,
	output reg spare_area_select_low,
	output reg write_guard_n,
	output reg [7:0] io_out,
	output reg io_oe,
	input wire [7:0] io_in,
	input wire ready_busy
);
	localparam ST_IDLE = 3'h0;
	localparam ST_WLOW = 3'h1;
	localparam ST_RLOW = 3'h2;
	localparam ST_REC = 3'h3;
	localparam ST_WB = 3'h4;
	localparam ST_RDY = 3'h5;
	localparam ST_HOLD = 3'h6;

	reg wr_pend;
	reg [7:0] wr_addr;
	reg [2:0] state;
	reg [12:0] cnt;
	reg [7:0] last_cmd;
	reg [7:0] rd_byte;
	reg [1:0] addr_cnt;
	reg [3:0] partial_cnt;
	reg check_pending;
	reg retire_go;
	reg refused;
	reg op_fail;
	reg fetch_late;
	reg not_erased;
	reg table_ready;
	reg [9:0] target;
	reg [1023:0] bad_table;
	reg [10:0] bad_count;
	reg [7:0] ecc_data;
	reg [4:0] ecc_check;
	reg [31:0] rd_word;
	wire [8:0] synced;
	wire [7:0] io_sync;
	wire rb_ready;
	wire [4:0] ecc_gen;
	wire [7:0] ecc_fixed;
	wire ecc_single;
	wire ecc_double;
	wire seq_busy;
	wire target_bad;
	wire cmd_go;
	wire [2:0] op_w;
	wire [7:0] byte_w;
	wire refuse;
	wire cap_read;
	wire st_clr;

	pin_sync #(.W(9)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin({ready_busy, io_in}),
		.stable(synced)
	);
	assign io_sync = synced[7:0];
	assign rb_ready = synced[8];

	ecc_secded u_ecc (
		.data(ecc_data),
		.check(ecc_check),
		.gen(ecc_gen),
		.fixed(ecc_fixed),
		.single_err(ecc_single),
		.double_err(ecc_double)
	);

	assign seq_busy = (state != ST_IDLE);
	assign target_bad = bad_table[target];
	assign cmd_go = wr_pend && (wr_addr == `REG_CMD);
	assign st_clr = wr_pend && (wr_addr == `REG_STATUS);
	assign op_w = hwdata[10:8];
	assign byte_w = hwdata[7:0];
	// A confirm to a retired block, an 11th partial program, or an erase
	// before the table exists never reaches the pins
	assign refuse = seq_busy ||
		((op_w == `OP_CMD) && (byte_w == `CMD_PROG_CONFIRM) &&
		(target_bad || (partial_cnt == `PARTIAL_MAX))) || // RULE_11 RULE_12
		((op_w == `OP_CMD) && (byte_w == `CMD_ERASE_CONFIRM) &&
		(target_bad || !table_ready)); // RULE_12 RULE_17 RULE_18
	assign cap_read = (state == ST_RLOW) && (cnt == `RD_LOW_CYC - 13'h0001);

	always @* begin
		rd_word = 32'h00000000;
		case (haddr[7:0])
		`REG_CFG: begin
			rd_word[0] = write_guard_n;
			rd_word[1] = spare_area_select_low;
			rd_word[2] = table_ready;
		end
		`REG_STATUS: begin
			rd_word[0] = seq_busy;
			rd_word[1] = rb_ready;
			rd_word[2] = refused;
			rd_word[3] = op_fail;
			rd_word[4] = fetch_late;
			rd_word[5] = not_erased;
			rd_word[6] = (bad_count > (`BLOCKS - `VALID_BLOCK_MIN)); // RULE_13
			rd_word[9:8] = addr_cnt;
			rd_word[15:12] = partial_cnt;
			rd_word[23:16] = rd_byte;
		end
		`REG_BLOCK: begin
			rd_word[9:0] = target;
			rd_word[16] = target_bad; // RULE_19
			rd_word[27:17] = bad_count;
		end
		`REG_ECC: begin
			rd_word[7:0] = ecc_fixed;
			rd_word[12:8] = ecc_gen;
			rd_word[16] = ecc_single;
			rd_word[17] = ecc_double;
		end
		default: rd_word = 32'h00000000;
		endcase
	end

	// Zero-wait slave: reads answer in the data phase, writes land then
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				wr_pend <= hwrite;
				wr_addr <= haddr[7:0];
				if (!hwrite)
					hrdata <= rd_word;
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_guard_n <= 1'b0;
			spare_area_select_low <= 1'b0;
			table_ready <= 1'b0;
			target <= 10'h000;
			ecc_data <= 8'h00;
			ecc_check <= 5'h00;
		end else if (wr_pend) begin
			if (wr_addr == `REG_CFG) begin
				write_guard_n <= hwdata[0]; // RULE_04
				spare_area_select_low <= hwdata[1]; // RULE_06
				table_ready <= hwdata[2];
			end
			if (wr_addr == `REG_BLOCK)
				target <= hwdata[9:0];
			if (wr_addr == `REG_ECC) begin
				ecc_data <= hwdata[7:0];
				ecc_check <= hwdata[12:8];
			end
		end
	end

	// Retirement by a failed status wins over a software mark that
	// lands in the same cycle; block zero is never marked
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bad_table <= {1024{1'b0}};
			bad_count <= 11'h000;
		end else if (retire_go && (target != 10'h000)) begin
			bad_table[target] <= 1'b1; // RULE_20
			if (!bad_table[target])
				bad_count <= bad_count + 11'h001;
		end else if (wr_pend && (wr_addr == `REG_BLOCK) && hwdata[16] &&
			(hwdata[9:0] != 10'h000)) begin // RULE_14
			bad_table[hwdata[9:0]] <= 1'b1; // RULE_17
			if (!bad_table[hwdata[9:0]])
				bad_count <= bad_count + 11'h001;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refused <= 1'b0;
			op_fail <= 1'b0;
			fetch_late <= 1'b0;
			not_erased <= 1'b0;
		end else begin
			// Hardware set beats a software clear in the same cycle
			if (cmd_go && refuse)
				refused <= 1'b1;
			else if (st_clr && hwdata[2])
				refused <= 1'b0;
			if (cap_read && check_pending && io_sync[0])
				op_fail <= 1'b1; // RULE_20
			else if (st_clr && hwdata[3])
				op_fail <= 1'b0;
			if ((state == ST_RDY) && !rb_ready && (cnt == `PAGE_FETCH_CYC))
				fetch_late <= 1'b1; // RULE_07
			else if (st_clr && hwdata[4])
				fetch_late <= 1'b0;
			if (cap_read && (last_cmd != `CMD_STATUS) &&
				(io_sync != `ERASED))
				not_erased <= 1'b1; // RULE_15 RULE_16
			else if (st_clr && hwdata[5])
				not_erased <= 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cnt <= 13'h0000;
			chip_select_n <= 1'b1;
			cmd_latch <= 1'b0;
			addr_latch <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_low <= 1'b1;
			io_out <= 8'h00;
			io_oe <= 1'b0;
			last_cmd <= `ERASED;
			rd_byte <= 8'h00;
			addr_cnt <= 2'h0;
			partial_cnt <= 4'h0;
			check_pending <= 1'b0;
			retire_go <= 1'b0;
		end else begin
			retire_go <= 1'b0;
			if (wr_pend && (wr_addr == `REG_BLOCK))
				partial_cnt <= 4'h0;
			case (state)
			ST_IDLE: begin
				cnt <= 13'h0000;
				if (cmd_go && !refuse) begin
					case (op_w)
					`OP_CMD, `OP_ADDR, `OP_WDATA: begin
						chip_select_n <= 1'b0;
						cmd_latch <= (op_w == `OP_CMD); // RULE_05
						addr_latch <= (op_w == `OP_ADDR); // RULE_05
						io_out <= byte_w;
						io_oe <= 1'b1;
						write_strobe_n <= 1'b0;
						state <= ST_WLOW;
						if (op_w == `OP_CMD) begin
							last_cmd <= byte_w;
							addr_cnt <= 2'h0;
							if (byte_w == `CMD_PROG_CONFIRM) begin
								partial_cnt <= partial_cnt + 4'h1; // RULE_11
								check_pending <= 1'b1;
							end
							if (byte_w == `CMD_ERASE_CONFIRM) begin
								partial_cnt <= 4'h0;
								check_pending <= 1'b1;
							end
						end else if ((op_w == `OP_ADDR) &&
							(addr_cnt != `ADDR_CLOCKS))
							addr_cnt <= addr_cnt + 2'h1; // RULE_05
					end
					`OP_RDATA: begin
						chip_select_n <= 1'b0;
						cmd_latch <= 1'b0;
						addr_latch <= 1'b0;
						io_oe <= 1'b0;
						read_strobe_low <= 1'b0;
						state <= ST_RLOW;
					end
					`OP_WAIT: state <= ST_WB;
					`OP_END: begin
						chip_select_n <= 1'b1; // RULE_10
						state <= ST_HOLD;
					end
					default: state <= ST_IDLE;
					endcase
				end
			end
			ST_WLOW: begin
				cnt <= cnt + 13'h0001;
				if (cnt == `WE_LOW_CYC - 13'h0001) begin
					// Rising edge latches byte as the latch levels say
					write_strobe_n <= 1'b1; // RULE_01 RULE_02
					cnt <= 13'h0000;
					state <= ST_REC;
				end
			end
			ST_RLOW: begin
				cnt <= cnt + 13'h0001;
				if (cap_read) begin
					rd_byte <= io_sync;
					read_strobe_low <= 1'b1;
					if (last_cmd == `CMD_STATUS) begin
						check_pending <= 1'b0;
						retire_go <= check_pending && io_sync[0]; // RULE_20
					end
					cnt <= 13'h0000;
					state <= ST_REC;
				end
			end
			ST_REC: begin
				// Long enough for every hold and cycle time of the strobes
				cnt <= cnt + 13'h0001;
				if (cnt == `WE_HIGH_CYC - 13'h0001) begin
					cmd_latch <= 1'b0;
					addr_latch <= 1'b0;
					io_oe <= 1'b0;
					cnt <= 13'h0000;
					state <= ST_IDLE;
				end
			end
			ST_WB: begin
				// Busy may take this long to appear, so ready is not
				// trusted before it has passed
				cnt <= cnt + 13'h0001;
				if (cnt == `WB_CYC - 13'h0001) begin // RULE_08 RULE_03
					cnt <= 13'h0000;
					state <= ST_RDY;
				end
			end
			ST_RDY: begin
				if (rb_ready) begin // RULE_03
					cnt <= 13'h0000;
					state <= ST_IDLE;
				end else if (cnt != `PAGE_FETCH_CYC)
					cnt <= cnt + 13'h0001;
			end
			ST_HOLD: begin
				cnt <= cnt + 13'h0001;
				if (cnt == `SELECT_HIGH_HOLD_CYC - 13'h0001) begin
					cnt <= 13'h0000;
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // nand_host

// ==== dv/nand_host_properties.sv ====
`timescale 1ns/1ns
module nand_host_properties (
	input wire clk,
	input wire rst_n,
	input wire chip_select_n,
	input wire cmd_latch,
	input wire addr_latch,
	input wire write_strobe_n,
	input wire read_strobe_low,
	input wire [7:0] io_out,
	input wire io_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_LATCH_EXCL: assert property (!(cmd_latch && addr_latch))
		else $error("both latches high");
	AST_LATCH_SELECT: assert property (
		(cmd_latch || addr_latch) |-> !chip_select_n)
		else $error("latch raised while deselected");
	AST_STROBE_EXCL: assert property (
		write_strobe_n || read_strobe_low)
		else $error("read and write strobes both active");
	AST_WRITE_DRIVES: assert property (
		!write_strobe_n |-> io_oe && !chip_select_n)
		else $error("write strobe without driven bus");
	AST_READ_RELEASES: assert property (
		!read_strobe_low |-> !io_oe && !chip_select_n)
		else $error("bus driven during read");
	AST_WRITE_PULSE: assert property (
		$fell(write_strobe_n) |-> !write_strobe_n[*4] ##1 write_strobe_n)
		else $error("write strobe width wrong");
	AST_BYTE_STABLE: assert property (
		!write_strobe_n && !$fell(write_strobe_n) |->
		$stable({io_out, cmd_latch, addr_latch}))
		else $error("byte or latch moved under write strobe");
	// Eight low samples: access time plus the pin synchroniser depth
	AST_READ_PULSE: assert property (
		$fell(read_strobe_low) |-> !read_strobe_low[*8] ##1 read_strobe_low)
		else $error("read strobe width wrong");
	AST_DESELECT_HOLD: assert property (
		$rose(chip_select_n) |-> chip_select_n[*8] ##1 chip_select_n[*5])
		else $error("deselect too short");
endmodule // nand_host_properties
bind nand_host nand_host_properties i_props (.clk(clk), .rst_n(rst_n),
	.chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
	.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
	.read_strobe_low(read_strobe_low), .io_out(io_out), .io_oe(io_oe));

// ==== dv/flash_model.sv ====
`timescale 1ns/1ns
module flash_model #(
	parameter BAD = 10'h005,
	parameter FETCH = 100,
	parameter BUSY = 200
) (
	input wire clk,
	input wire chip_select_n,
	input wire cmd_latch,
	input wire addr_latch,
	input wire write_strobe_n,
	input wire read_strobe_low,
	input wire write_guard_n,
	input wire [7:0] io_out,
	input wire fail,
	output wire [7:0] io_in,
	output wire ready_busy
);
	reg [7:0] cmd = 8'hFF;
	reg [7:0] row_lo = 8'h00;
	reg [7:0] row_hi = 8'h00;
	reg [7:0] last = 8'hFF;
	reg [1:0] naddr = 2'h0;
	reg ws_q = 1'b1;
	reg failed = 1'b0;
	integer cnt = 0;
	wire [9:0] blk = {row_hi[5:0], row_lo[7:4]};
	wire start = write_guard_n && (io_out == 8'h10 || io_out == 8'hD0);
	wire [7:0] dout = (cmd == 8'h70) ? {1'b1, ready_busy, 5'h00, failed} :
		(blk == BAD && row_lo[3:1] == 3'h0) ? 8'h00 : 8'hFF;
	// Released bus shows the inverse, so a stale byte can never pass
	assign #30 io_in = (!read_strobe_low && !chip_select_n) ? dout : ~last;
	assign ready_busy = (cnt == 0);
	always @(posedge clk) begin
		ws_q <= write_strobe_n;
		if (!read_strobe_low)
			last <= dout;
		if (cnt > 0)
			cnt <= cnt - 1;
		// A deselect ends a read fetch, so no busy follows it
		if (chip_select_n && cmd == 8'h00)
			cnt <= 0;
		if (write_strobe_n && !ws_q && !chip_select_n) begin
			if (cmd_latch) begin
				cmd <= io_out;
				naddr <= 2'h0;
				if (start) begin
					cnt <= BUSY;
					failed <= fail;
				end
			end else if (addr_latch) begin
				naddr <= naddr + 2'h1;
				if (naddr == 2'h1)
					row_lo <= io_out;
				if (naddr == 2'h2) begin
					row_hi <= io_out;
					if (cmd == 8'h00)
						cnt <= FETCH;
				end
			end
		end
	end
endmodule // flash_model

// ==== dv/test_nand_host.sv ====
`timescale 1ns/1ns
module test_nand_host;
	logic clk, rst_n, hsel, hwrite, fail_on;
	logic [31:0] haddr, hwdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] g;
	wire hready, hresp, chip_select_n, cmd_latch, addr_latch, io_oe;
	wire write_strobe_n, read_strobe_low, spare_area_select_low;
	wire write_guard_n, ready_busy;
	wire [31:0] hrdata;
	wire [7:0] io_out, io_in;
	int fails, checks;
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	nand_host i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.read_strobe_low(read_strobe_low),
		.spare_area_select_low(spare_area_select_low),
		.write_guard_n(write_guard_n), .io_out(io_out), .io_oe(io_oe),
		.io_in(io_in), .ready_busy(ready_busy));
	flash_model i_flash (.clk(clk), .chip_select_n(chip_select_n),
		.cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.write_strobe_n(write_strobe_n), .read_strobe_low(read_strobe_low),
		.write_guard_n(write_guard_n), .io_out(io_out), .fail(fail_on),
		.io_in(io_in), .ready_busy(ready_busy));
	task automatic print_verdict;
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rv = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(0, a, 32'h0);
	endtask
	// Busy rises a cycle after the write, so polling starts two edges late
	task automatic op(input logic [2:0] o, input logic [7:0] b);
		int n;
		wr(8'h00, {21'h0, o, b});
		repeat (2) @(posedge clk);
		n = 0;
		do begin
			rd(8'h08);
			n++;
		end while (rv[0] !== 1'b0 && n < 400);
		chk(rv[0], 0);
	endtask
	task automatic stat;
		op(5, 0);
		op(1, 8'h70);
		op(4, 0);
	endtask
	task automatic rdpg(input logic [9:0] b);
		op(1, 8'h00);
		op(2, 8'h00);
		op(2, {b[3:0], 4'h0});
		op(2, {2'h0, b[9:4]});
		op(5, 0);
		op(4, 0);
	endtask
	task automatic erase(input logic [9:0] b);
		op(1, 8'h60);
		op(2, {b[3:0], 4'h0});
		op(2, {2'h0, b[9:4]});
		op(1, 8'hD0);
		stat();
	endtask
	task automatic prog;
		op(1, 8'h80);
		repeat (3) op(2, 8'h00);
		op(3, 8'h5A);
		op(1, 8'h10);
		stat();
	endtask
	initial begin
		rst_n = 0;
		hsel = 0;
		hwrite = 0;
		fail_on = 0;
		haddr = 0;
		hwdata = 0;
		htrans = 0;
		hsize = 3'h2;
		fails = 0;
		checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		chk(chip_select_n, 1);
		rd(8'h04);
		chk(rv, 0);
		rd(8'h20);
		chk(rv, 0);
		wr(8'h04, 32'h1);
		rd(8'h04);
		chk({write_guard_n, rv[0]}, 2'h3);
		rdpg(10'h005);
		chk(rv[23:16], 8'h00);
		chk(rv[5], 1);
		chk(rv[9:8], 2'h3);
		rdpg(10'h001);
		chk(rv[23:16], 8'hFF);
		wr(8'h0C, 32'h10005);
		wr(8'h0C, 32'h10000);
		rd(8'h0C);
		chk(rv[27:17], 1);
		erase(10'h003);
		chk(rv[3:2], 2'h1);
		wr(8'h04, 32'h5);
		wr(8'h08, 32'h3C);
		wr(8'h0C, 32'h5);
		erase(10'h005);
		chk(rv[3:2], 2'h1);
		wr(8'h08, 32'h3C);
		wr(8'h0C, 32'h3);
		erase(10'h003);
		chk(rv[3:2], 2'h0);
		for (int i = 0; i < 10; i++)
			prog();
		chk(rv[15:12], 4'hA);
		chk(rv[6], 0);
		op(1, 8'h10);
		chk(rv[2], 1);
		fail_on <= 1;
		wr(8'h08, 32'h3C);
		wr(8'h0C, 32'h7);
		prog();
		chk(rv[3], 1);
		rd(8'h0C);
		chk(rv[27:16], 12'h005);
		wr(8'h08, 32'h3C);
		op(1, 8'h10);
		chk(rv[2], 1);
		wr(8'h10, 32'hA5);
		rd(8'h10);
		g = rv[12:8];
		wr(8'h10, {19'h0, g, 8'hA4});
		rd(8'h10);
		chk(rv[7:0], 8'hA5);
		chk(rv[17:16], 2'h1);
		wr(8'h10, {19'h0, g, 8'hA6});
		rd(8'h10);
		chk(rv[17:16], 2'h2);
		op(6, 0);
		chk(chip_select_n, 1);
		wr(8'h04, 32'h7);
		rd(8'h04);
		chk({spare_area_select_low, rv[2:0]}, 4'hF);
		print_verdict();
	end
	initial begin
		#400000;
		fails++;
		print_verdict();
	end
endmodule // test_nand_host
